// ==== src/iosrfb_frame_builder.sv ====
// short-address sample report frame builder feeding the serial byte stream
//
// Summary of operation
// R1 - one report frame per received short-address sample
// R2 - frame type 0x83 at offset three
// R3 - sender short address, high byte first
// R4 - signal strength magnitude byte at offset six
// R5 - options byte, broadcast bits only, rest zero
// R6 - sample set count byte at offset eight
// R7 - channel mask, high then low byte
// R8 - mask: reserved three, analog four, digital nine
// R9 - digital levels word, masked, when any enabled
// R10 - no digital line enabled: omit digital word
// R11 - per analog input, right-aligned ten-bit word
// R12 - analog words ascending, disabled inputs skipped
// R13 - delimiter, length before; checksum after data
`timescale 1ns/1ps
`default_nettype none
`include "iosrfb_regs.svh"

module io_sample_rx_frame_builder #(
    parameter int ANALOG_CH = `IOSRFB_DEF_ANALOG_CH,
    parameter int DIGITAL_LINES = `IOSRFB_DEF_DIGITAL_LINES,
    parameter int ADC_BITS = `IOSRFB_DEF_ADC_BITS,
    parameter int FIFO_DEPTH = `IOSRFB_DEF_FIFO_DEPTH,
    parameter logic [7:0] DELIMITER = `IOSRFB_DELIM
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // received sample from the radio side
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    input wire logic [15:0] src_addr_i,
    input wire logic [7:0] rssi_i,
    input wire logic [7:0] rx_options_i,
    input wire logic [7:0] sample_count_i,
    input wire logic [15:0] channel_mask_i,
    input wire logic [DIGITAL_LINES-1:0] digital_levels_i,
    input wire logic [ANALOG_CH*ADC_BITS-1:0] analog_samples_i,
    // serial byte stream toward the host
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    // status
    output logic busy_o
);

    localparam int CHW = (ANALOG_CH > 1) ? $clog2(ANALOG_CH) : 1;
    localparam int WW = `IOSRFB_WORD_W;

    iosrfb_pkg::iosrfb_state_type state;
    logic [3:0] step;
    logic [CHW-1:0] ch;
    logic phase;
    logic [7:0] sum;

    logic [15:0] addr_q;
    logic [7:0] rssi_q;
    logic [7:0] opts_q;
    logic [7:0] count_q;
    logic [15:0] mask_q;
    logic [DIGITAL_LINES-1:0] dig_q;
    logic [ANALOG_CH*ADC_BITS-1:0] ana_q;
    logic [15:0] len_q;

    logic capture;
    logic [15:0] next_len;
    logic [15:0] next_mask;
    logic [ANALOG_CH-1:0] ana_en;
    logic dig_any;
    logic [WW-1:0] dig_word;
    logic [WW-1:0] ana_word;
    logic ch_on;
    logic ch_last;
    logic push_valid;
    logic push_ready;
    logic push_fire;
    logic [7:0] cur_byte;
    logic in_sum;
    // sequencer events
    logic field_done;
    logic word_done;
    logic frame_done;

    ////////////////////////////////////////////////////////////////////////
    // intake: one sample at a time; the radio side waits while a frame is built
    assign capture = sample_valid_i & sample_ready_o;
    assign next_mask = channel_mask_i & `IOSRFB_MASK_KEEP; // see R8

    // length counts frame data only: type byte through the last sample
    always_comb begin
        next_len = `IOSRFB_FIXED_LEN;
        if (next_mask[DIGITAL_LINES-1:0] != '0) begin
            next_len = next_len + `IOSRFB_DIG_LEN; // see R9
        end
        for (int i = 0; i < ANALOG_CH; i++) begin
            if (next_mask[DIGITAL_LINES + i]) begin
                next_len = next_len + `IOSRFB_WORD_LEN; // see R11
            end
        end
    end

    // header fields of the report, stored as they arrive
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_q <= '0;
            rssi_q <= '0;
            opts_q <= '0;
            count_q <= '0;
        end else if (ce_i && capture) begin
            addr_q <= src_addr_i;
            rssi_q <= rssi_i;
            opts_q <= rx_options_i & `IOSRFB_OPT_KEEP; // see R5
            count_q <= sample_count_i;
        end
    end

    // channel layout and the frame length it implies
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= '0;
            len_q <= '0;
        end else if (ce_i && capture) begin
            mask_q <= next_mask;
            len_q <= next_len;
        end
    end

    // sample values; held for the whole frame since the radio side may move on
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dig_q <= '0;
            ana_q <= '0;
        end else if (ce_i && capture) begin
            dig_q <= digital_levels_i;
            ana_q <= analog_samples_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field views of the captured sample
    assign ana_en = mask_q[DIGITAL_LINES +: ANALOG_CH]; // see R8
    assign dig_any = (mask_q[DIGITAL_LINES-1:0] != '0);
    // disabled lines read as zero whatever their pin level
    assign dig_word = WW'(dig_q & mask_q[DIGITAL_LINES-1:0]); // see R9
    assign ana_word = WW'(ana_q[ch*ADC_BITS +: ADC_BITS]); // see R11
    assign ch_on = ana_en[ch];
    assign ch_last = (ch == CHW'(ANALOG_CH-1));

    ////////////////////////////////////////////////////////////////////////
    // byte selection for the current position in the frame
    always_comb begin
        cur_byte = '0;
        case (state)
            iosrfb_pkg::st_field: begin
                case (step)
                    `IOSRFB_OFF_DELIM: cur_byte = DELIMITER; // see R13
                    `IOSRFB_OFF_LEN_HI: cur_byte = len_q[15:8]; // see R13
                    `IOSRFB_OFF_LEN_LO: cur_byte = len_q[7:0]; // see R13
                    `IOSRFB_OFF_TYPE: cur_byte = `IOSRFB_FRAME_TYPE; // see R2
                    `IOSRFB_OFF_ADDR_HI: cur_byte = addr_q[15:8]; // see R3
                    `IOSRFB_OFF_ADDR_LO: cur_byte = addr_q[7:0]; // see R3
                    `IOSRFB_OFF_RSSI: cur_byte = rssi_q; // see R4
                    `IOSRFB_OFF_OPTS: cur_byte = opts_q; // see R5
                    `IOSRFB_OFF_COUNT: cur_byte = count_q; // see R6
                    `IOSRFB_OFF_MASK_HI: cur_byte = mask_q[15:8]; // see R7
                    `IOSRFB_OFF_MASK_LO: cur_byte = mask_q[7:0]; // see R7
                    `IOSRFB_OFF_DIG_HI: cur_byte = dig_word[15:8]; // see R9
                    `IOSRFB_OFF_DIG_LO: cur_byte = dig_word[7:0]; // see R9
                    default: cur_byte = '0;
                endcase
            end
            iosrfb_pkg::st_analog: begin
                cur_byte = phase ? ana_word[7:0] : ana_word[15:8]; // see R11
            end
            iosrfb_pkg::st_check: begin
                cur_byte = `IOSRFB_CSUM_BASE - sum; // see R13
            end
            default: cur_byte = '0;
        endcase
    end

    // a disabled analog input costs one idle cycle rather than a lookahead
    always_comb begin
        push_valid = 1'b0;
        case (state)
            iosrfb_pkg::st_field: push_valid = 1'b1;
            iosrfb_pkg::st_analog: push_valid = ch_on; // see R12
            iosrfb_pkg::st_check: push_valid = 1'b1;
            default: push_valid = 1'b0;
        endcase
    end

    assign push_fire = push_valid & push_ready;
    // checksum covers frame data only: from the type byte to the last sample
    assign in_sum = (state == iosrfb_pkg::st_analog) ||
                    ((state == iosrfb_pkg::st_field) && (step >= `IOSRFB_OFF_TYPE));

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer, one register per concern
    // the fixed part ends at the mask, or at the digital word when one is sent
    assign field_done = (state == iosrfb_pkg::st_field) && push_fire &&
                        ((step == `IOSRFB_OFF_DIG_LO) ||
                         ((step == `IOSRFB_OFF_MASK_LO) && !dig_any)); // see R10
    // an analog slot ends on its low byte, or at once when its input is off
    assign word_done = (state == iosrfb_pkg::st_analog) && (!ch_on || (push_fire && phase));
    assign frame_done = (state == iosrfb_pkg::st_check) && push_fire;

    // unknown state codes fall back to idle; sample_ready_o is not set again, so a code hit mid-frame still locks the port
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= iosrfb_pkg::st_idle;
        end else if (ce_i) begin
            case (state)
                iosrfb_pkg::st_idle: begin
                    if (capture) begin
                        state <= iosrfb_pkg::st_field; // see R1
                    end
                end
                iosrfb_pkg::st_field: begin
                    if (field_done) begin
                        state <= iosrfb_pkg::st_analog;
                    end
                end
                iosrfb_pkg::st_analog: begin
                    if (word_done && ch_last) begin
                        state <= iosrfb_pkg::st_check;
                    end
                end
                iosrfb_pkg::st_check: begin
                    if (frame_done) begin
                        state <= iosrfb_pkg::st_idle;
                    end
                end
                default: begin
                    state <= iosrfb_pkg::st_idle;
                end
            endcase
        end
    end

    // position within the fixed part of the frame
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            step <= `IOSRFB_OFF_DELIM;
        end else if (ce_i) begin
            if (capture) begin
                step <= `IOSRFB_OFF_DELIM;
            end else if ((state == iosrfb_pkg::st_field) && push_fire && !field_done) begin
                step <= step + 4'h1;
            end
        end
    end

    // analog input index, lowest input first
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ch <= '0;
        end else if (ce_i) begin
            if (field_done) begin
                ch <= '0;
            end else if (word_done && !ch_last) begin
                ch <= ch + 1'b1; // see R12
            end
        end
    end

    // byte of the current analog word, high byte first
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase <= 1'b0;
        end else if (ce_i) begin
            if (field_done || word_done) begin
                phase <= 1'b0;
            end else if ((state == iosrfb_pkg::st_analog) && push_fire) begin
                phase <= 1'b1; // see R11
            end
        end
    end

    // the sum restarts on each take, so no earlier frame leaks into it
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sum <= '0;
        end else if (ce_i) begin
            if (capture) begin
                sum <= '0;
            end else if (push_fire && in_sum) begin
                sum <= sum + cur_byte; // see R13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handshake toward the radio side: a taken sample waits for its checksum push
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_ready_o <= 1'b1;
        end else if (ce_i) begin
            if (capture) begin
                sample_ready_o <= 1'b0;
            end else if (frame_done) begin
                sample_ready_o <= 1'b1;
            end
        end
    end

    // status: busy from the take until the whole frame sits in the buffer
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o <= 1'b0;
        end else if (ce_i) begin
            if (capture) begin
                busy_o <= 1'b1; // see R1
            end else if (frame_done) begin
                busy_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffer; a stalled host backs up into the sequencer
    iosrfb_fifo #(
        .WIDTH(`IOSRFB_DEF_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(cur_byte),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );

endmodule

`default_nettype wire

// ==== src/iosrfb_regs.svh ====
// frame layout constants for the short-address sample report builder
`ifndef IOSRFB_REGS_SVH
`define IOSRFB_REGS_SVH

`define IOSRFB_DELIM 8'h7E
`define IOSRFB_FRAME_TYPE 8'h83
`define IOSRFB_OPT_KEEP 8'h06
`define IOSRFB_MASK_KEEP 16'h1FFF
`define IOSRFB_CSUM_BASE 8'hFF
`define IOSRFB_FIXED_LEN 16'h0008
`define IOSRFB_DIG_LEN 16'h0002
`define IOSRFB_WORD_LEN 16'h0002
`define IOSRFB_WORD_W 16

`define IOSRFB_OFF_DELIM 4'h0
`define IOSRFB_OFF_LEN_HI 4'h1
`define IOSRFB_OFF_LEN_LO 4'h2
`define IOSRFB_OFF_TYPE 4'h3
`define IOSRFB_OFF_ADDR_HI 4'h4
`define IOSRFB_OFF_ADDR_LO 4'h5
`define IOSRFB_OFF_RSSI 4'h6
`define IOSRFB_OFF_OPTS 4'h7
`define IOSRFB_OFF_COUNT 4'h8
`define IOSRFB_OFF_MASK_HI 4'h9
`define IOSRFB_OFF_MASK_LO 4'hA
`define IOSRFB_OFF_DIG_HI 4'hB
`define IOSRFB_OFF_DIG_LO 4'hC

`define IOSRFB_DEF_ANALOG_CH 4
`define IOSRFB_DEF_DIGITAL_LINES 9
`define IOSRFB_DEF_ADC_BITS 10
`define IOSRFB_DEF_FIFO_DEPTH 32
`define IOSRFB_DEF_FIFO_WIDTH 8

`endif

// ==== src/iosrfb_pkg.sv ====
// types shared by the sample report builder
package iosrfb_pkg;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_field = 4'b0010,
        st_analog = 4'b0100,
        st_check = 4'b1000
    } iosrfb_state_type;

endpackage

// ==== src/iosrfb_fifo.sv ====
// byte fifo with a registered output stage
`timescale 1ns/1ps
`default_nettype none
`include "iosrfb_regs.svh"

module iosrfb_fifo #(
    parameter int WIDTH = `IOSRFB_DEF_FIFO_WIDTH,
    parameter int DEPTH = `IOSRFB_DEF_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic wr_fire;
    logic load;

    ////////////////////////////////////////////////////////////////////////
    // full is honest: a slot freed by this cycle's load is not reused yet
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign wr_fire = in_valid_i & in_ready_o;
    assign load = (count != '0) & (~out_valid_o | out_ready_i);

    always_ff @(posedge clock_i) begin
        if (ce_i && wr_fire) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce_i) begin
            if (wr_fire) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (load) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(wr_fire) - (AW+1)'(load);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (ce_i) begin
            if (load) begin
                out_data_o <= mem[rd_ptr];
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/iosrfb_host_model.sv ====
// host model pacing the serial byte stream
`timescale 1ns/1ps
`default_nettype none
module iosrfb_host_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // pace: 0 prompt, 1 random stalls, 2 blocked
    input wire logic [1:0] mode_i,
    // byte handshake
    output logic tx_ready_o
);
    logic [7:0] lfsr;
    // stalls fall anywhere, not only between frames, as a real host may
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lfsr <= 8'hA5;
            tx_ready_o <= 1'b0;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            tx_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && lfsr[0]);
        end
    end
endmodule
`default_nettype wire

// ==== tb/iosrfb_frame_assertions.sv ====
// port checker for the sample report builder
`timescale 1ns/1ps
`default_nettype none
module iosrfb_frame_assertions (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // sample side
    input wire logic sample_valid_i,
    input wire logic sample_ready_o,
    input wire logic busy_o,
    // byte side
    input wire logic [7:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i
);
    logic [4:0] pos;
    logic [15:0] len;
    logic [7:0] sum;
    wire logic tk = ce_i && tx_valid_o && tx_ready_i;
    wire logic last = tk && pos > 5'h3 && pos == len + 16'h3;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // position runs from the delimiter, so a lost byte shifts every field
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos <= 5'h0;
        end else if (tk) begin
            pos <= last ? 5'h0 : pos + 5'h1;
        end
    end
    always_ff @(posedge clock_i) begin
        if (tk && pos == 5'h1) len[15:8] <= tx_data_o;
        if (tk && pos == 5'h2) len[7:0] <= tx_data_o;
        if (tk) sum <= (pos == 5'h3) ? tx_data_o : sum + tx_data_o;
    end
    ready_busy_a: assert property (sample_ready_o == !busy_o)
        else $error("ready and busy disagree");
    take_answer_a: assert property (ce_i && sample_valid_i && sample_ready_o |=> busy_o)
        else $error("sample take not answered");
    byte_hold_a: assert property (tx_valid_o && !(ce_i && tx_ready_i) |=> tx_valid_o && $stable(tx_data_o))
        else $error("byte dropped before taken");
    delim_byte_a: assert property (tk && pos == 5'h0 |-> tx_data_o == 8'h7E)
        else $error("bad delimiter");
    type_byte_a: assert property (tk && pos == 5'h3 |-> tx_data_o == 8'h83)
        else $error("bad frame type");
    opts_rsv_a: assert property (tk && pos == 5'h7 |-> !tx_data_o[0] && tx_data_o[7:3] == 5'h0)
        else $error("options reserved bits set");
    mask_rsv_a: assert property (tk && pos == 5'h9 |-> tx_data_o[7:5] == 3'h0)
        else $error("mask reserved bits set");
    check_sum_a: assert property (last |-> 8'(sum + tx_data_o) == 8'hFF)
        else $error("bad checksum");
endmodule
bind io_sample_rx_frame_builder iosrfb_frame_assertions i_chk (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .ce_i(ce_i), .sample_valid_i(sample_valid_i), .busy_o(busy_o),
    .sample_ready_o(sample_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i));
`default_nettype wire

// ==== tb/tb_io_sample_rx_frame_builder.sv ====
// bench for the sample report builder
`timescale 1ns/1ps
`default_nettype none
module tb_io_sample_rx_frame_builder;
    logic clock_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b0, sample_valid_i = 1'b0, ce_rand = 1'b0;
    logic [15:0] src_addr_i = '0, channel_mask_i = '0;
    logic [7:0] rssi_i = '0, rx_options_i = '0, sample_count_i = '0, sum;
    logic [8:0] digital_levels_i = '0;
    logic [39:0] analog_samples_i = '0;
    logic [1:0] host_mode = 2'h0;
    wire logic sample_ready_o, tx_valid_o, tx_ready_i, busy_o;
    wire logic [7:0] tx_data_o;
    logic [7:0] exp_q[$];
    logic [15:0] masks[6] = '{16'h0000, 16'hFFFF, 16'h0200, 16'h1000, 16'h0100, 16'h0E01};
    int n_mismatch = 0, tests_run = 0, seed = 62433, k;
    always #2.5 clock_i = ~clock_i;
    io_sample_rx_frame_builder i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .src_addr_i(src_addr_i), .rssi_i(rssi_i), .rx_options_i(rx_options_i),
        .sample_count_i(sample_count_i), .channel_mask_i(channel_mask_i),
        .digital_levels_i(digital_levels_i), .analog_samples_i(analog_samples_i),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .busy_o(busy_o));
    iosrfb_host_model i_host (.clock_i(clock_i), .rst_b_i(rst_b_i), .mode_i(host_mode),
        .tx_ready_o(tx_ready_i));
    task give_verdict;
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task timed_out;
        n_mismatch++;
        $display("Error %0t wait limit used up", $time);
        give_verdict();
    endtask
    task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t byte %h, expected %h", $time, got, exp);
        end
    endtask
    task cmp_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t flag %b, expected %b", $time, got, exp);
        end
    endtask
    task put(input logic [7:0] b, input int add);
        exp_q.push_back(b);
        if (add != 0) sum = sum + b;
    endtask
    // expected frame is noted before the take, the monitor pops per byte
    task send(input logic [15:0] m);
        logic [15:0] a;
        logic [7:0] r, o, c, len;
        logic [8:0] dl;
        logic [39:0] an;
        int i;
        a = 16'($random(seed));
        r = 8'($random(seed));
        o = 8'($random(seed));
        c = 8'($random(seed));
        dl = 9'($random(seed));
        an = 40'({$random(seed), $random(seed)});
        len = (m[8:0] != 0) ? 8'hA : 8'h8;
        for (i = 0; i < 4; i++) len = len + {m[9 + i], 1'b0};
        sum = 8'h00;
        put(8'h7E, 0);
        put(8'h00, 0);
        put(len, 0);
        put(8'h83, 1);
        put(a[15:8], 1);
        put(a[7:0], 1);
        put(r, 1);
        put(o & 8'h06, 1);
        put(c, 1);
        put(m[15:8] & 8'h1F, 1);
        put(m[7:0], 1);
        if (m[8:0] != 0) begin
            put({7'h00, dl[8] & m[8]}, 1);
            put(dl[7:0] & m[7:0], 1);
        end
        for (i = 0; i < 4; i++) begin
            if (m[9 + i]) begin
                put({6'h00, an[i * 10 + 8 +: 2]}, 1);
                put(an[i * 10 +: 8], 1);
            end
        end
        put(8'hFF - sum, 0);
        @(posedge clock_i);
        src_addr_i <= a;
        rssi_i <= r;
        rx_options_i <= o;
        sample_count_i <= c;
        channel_mask_i <= m;
        digital_levels_i <= dl;
        analog_samples_i <= an;
        sample_valid_i <= 1'b1;
        for (i = 0; i < 3000; i++) begin
            @(posedge clock_i);
            if (ce_i && sample_ready_o) break;
        end
        if (i == 3000) timed_out();
        sample_valid_i <= 1'b0;
    endtask
    task drain;
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge clock_i);
            if (exp_q.size() == 0 && sample_ready_o) break;
        end
        if (i == 3000) timed_out();
    endtask
    task check_reset;
        cmp_flag(sample_ready_o, 1'b1);
        cmp_flag(busy_o, 1'b0);
        cmp_flag(tx_valid_o, 1'b0);
        cmp_byte(tx_data_o, 8'h00);
    endtask
    always @(posedge clock_i) begin
        ce_i <= ce_rand ? ($random(seed) % 4 != 0) : 1'b1;
        if (rst_b_i && ce_i && tx_valid_o && tx_ready_i) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("Error %0t byte without a sample", $time);
            end else begin
                cmp_byte(tx_data_o, exp_q.pop_front());
            end
        end
    end
    initial begin
        repeat (8) @(posedge clock_i);
        check_reset();
        rst_b_i <= 1'b1;
        for (k = 0; k < 6; k++) send(masks[k]);
        drain();
        host_mode <= 2'h1;
        ce_rand <= 1'b1;
        for (k = 0; k < 12; k++) send(16'($random(seed)));
        drain();
        // blocked host: two long frames overrun the fifo and stall the builder
        ce_rand <= 1'b0;
        host_mode <= 2'h2;
        send(16'h1FFF);
        send(16'h1FFF);
        repeat (40) @(posedge clock_i);
        cmp_flag(sample_ready_o, 1'b0);
        host_mode <= 2'h0;
        drain();
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        check_reset();
        rst_b_i <= 1'b1;
        send(16'h0155);
        drain();
        give_verdict();
    end
endmodule
`default_nettype wire
